// *** ssc_pkg.sv ***
// Package for the serial status/control block: register map, fields, types.
// Assumes an APB slave with 32-bit data; registers sit in the low byte.
package ssc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_FRAME = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_MODE = 8'h10;
  // Status field positions
  localparam int ST_TXE = 7;
  localparam int ST_TXC = 6;
  localparam int ST_RXR = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVR = 3;
  localparam int ST_NOISE = 2;
  localparam int ST_FRM = 1;
  localparam int ST_PAR = 0;
  // Frame control field positions
  localparam int FC_RX9 = 7;
  localparam int FC_TX9 = 6;
  localparam int FC_LPD = 5;
  localparam int FC_WLEN = 4;
  localparam int FC_WAKE = 3;
  localparam int FC_PEN = 2;
  localparam int FC_PSEL = 1;
  localparam int FC_PIE = 0;
  // Enable control field positions
  localparam int EC_TIE = 7;
  localparam int EC_TRANSMIT_COMPLETE_IRQ_EN = 6;
  localparam int EC_RIE = 5;
  localparam int EC_IDLE_IRQ_EN = 4;
  localparam int EC_MUTE = 1;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'hC0;
  localparam logic [7:0] FRAME_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  // Clear sequence states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ARMED = 2'b01
  } ssc_seq_t;
  // Receive side event bundle from the shift engine
  typedef struct packed {
    logic word_done;
    logic [8:0] word;
    logic noise;
    logic framing;
    logic idle_line;
    logic addr_mark;
  } ssc_rx_ev_t;
  // Whole block state
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] frame;
    logic [7:0] enable;
    logic [8:0] rx_hold;
    logic [8:0] tx_hold;
    logic idle_armed;
    ssc_seq_t seq;
    logic [1:0] fmt_live;
    logic [2:0] mode_live;
    logic [31:0] prdata;
    logic [1:0] halt_sync;
  } ssc_state_t;
endpackage

// *** ssc_core.sv ***
// Status, interrupt and frame-format logic of an asynchronous serial interface.
// Assumes APB master on pclk; shift engines and baud generator sit outside.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ssc_core (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor state
  input wire logic global_mask,
  input wire logic halt_mode,
  // Transmit engine
  output logic tx_load,
  output logic [8:0] tx_word,
  input wire logic tx_shift_free,
  input wire logic tx_data_done,
  input wire logic tx_special_done,
  input wire logic byte_boundary,
  // Receive engine
  input wire ssc_pkg::ssc_rx_ev_t rx_ev,
  // Engine control
  output logic engine_run,
  output logic nine_bit,
  output logic parity_on,
  output logic parity_odd,
  output logic wake_addr,
  // Interrupt request
  output logic irq,
  output logic wake_request
);
  ssc_pkg::ssc_state_t st_reg; // Registered state
  ssc_pkg::ssc_state_t st_next; // Next state
  logic acc; // Access phase
  logic wr; // Write access
  logic rd; // Read access
  logic data_wr; // Data port write
  logic data_rd; // Data port read
  logic run; // Engines permitted to run
  logic muted; // Receiver muted
  logic [7:0] rx_low; // Received low byte
  logic par_bad; // Parity mismatch
  logic overrun; // Word lands on full holder
  logic [7:0] flags_in; // Set events

  // Parity of a byte, odd sense selectable
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction

  // Bus decode; always zero wait states
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign data_wr = wr && (paddr == ssc_pkg::OFS_DATA);
  assign data_rd = rd && (paddr == ssc_pkg::OFS_DATA);
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = st_reg.prdata;

  // Halt freezes engines; low power stops after the byte
  assign run = !st_reg.halt_sync[1] && !st_reg.mode_live[2];
  assign engine_run = run;
  assign nine_bit = st_reg.frame[ssc_pkg::FC_WLEN];
  assign parity_on = st_reg.fmt_live[1];
  assign parity_odd = st_reg.fmt_live[0];
  assign wake_addr = st_reg.mode_live[0];
  assign muted = st_reg.enable[ssc_pkg::EC_MUTE];

  // Shifter load only while holder is full and transmit empty clear
  assign tx_load = run && tx_shift_free && !st_reg.status[ssc_pkg::ST_TXE];
  assign tx_word = st_reg.tx_hold;

  // Receive checks
  assign rx_low = rx_ev.word[7:0];
  assign par_bad = st_reg.fmt_live[1] &&
    (nine_bit ? par_of(rx_low, st_reg.fmt_live[0])
              : par_of({1'b0, rx_low[6:0]}, st_reg.fmt_live[0]) != rx_low[7]);
  assign overrun = st_reg.status[ssc_pkg::ST_RXR];

  // Set events from engines
  always_comb begin
    flags_in = 8'h00;
    flags_in[ssc_pkg::ST_TXE] = tx_load;
    flags_in[ssc_pkg::ST_TXC] = run && tx_data_done && !tx_special_done;
    if (run && rx_ev.word_done && !muted) begin
      if (overrun) begin
        flags_in[ssc_pkg::ST_OVR] = 1'b1;
      end else begin
        flags_in[ssc_pkg::ST_RXR] = 1'b1;
        flags_in[ssc_pkg::ST_FRM] = rx_ev.framing;
        flags_in[ssc_pkg::ST_PAR] = nine_bit ? (par_bad ^ rx_ev.word[8]) && st_reg.fmt_live[1]
                                             : par_bad;
      end
      flags_in[ssc_pkg::ST_NOISE] = rx_ev.noise;
    end
    if (run && rx_ev.idle_line && !muted && st_reg.idle_armed) begin
      flags_in[ssc_pkg::ST_IDLE] = 1'b1;
    end
  end

  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.halt_sync = {st_reg.halt_sync[0], halt_mode};
    // Parity, wake and low-power bits take effect only at a byte boundary
    if (byte_boundary) begin
      st_next.fmt_live = {st_reg.frame[ssc_pkg::FC_PEN], st_reg.frame[ssc_pkg::FC_PSEL]};
      st_next.mode_live = {st_reg.frame[ssc_pkg::FC_LPD], 1'b0,
                           st_reg.frame[ssc_pkg::FC_WAKE]};
    end
    // Clear sequence: status access arms, matching data access clears
    if (acc && paddr == ssc_pkg::OFS_STATUS) begin
      st_next.seq = ssc_pkg::SEQ_ARMED;
    end else if (data_wr || data_rd) begin
      st_next.seq = ssc_pkg::SEQ_IDLE;
      if (st_reg.seq == ssc_pkg::SEQ_ARMED) begin
        if (data_wr) begin
          st_next.status[ssc_pkg::ST_TXE] = 1'b0;
          st_next.status[ssc_pkg::ST_TXC] = 1'b0;
        end else begin
          st_next.status[5:1] = 5'b0_0000;
          if (st_reg.status[ssc_pkg::ST_IDLE]) begin
            st_next.idle_armed = 1'b0;
          end
        end
        st_next.status[ssc_pkg::ST_PAR] = 1'b0;
      end
    end
    // Data register write fills holder
    if (data_wr) begin
      st_next.tx_hold = {st_reg.frame[ssc_pkg::FC_TX9], pwdata[7:0]};
      if (st_reg.fmt_live[1]) begin
        if (nine_bit) begin
          st_next.tx_hold[8] = par_of(pwdata[7:0], st_reg.fmt_live[0]);
        end else begin
          st_next.tx_hold[7] = par_of({1'b0, pwdata[6:0]}, st_reg.fmt_live[0]);
        end
      end
    end
    // Received word into holder unless overrun
    if (run && rx_ev.word_done && !muted && !overrun) begin
      st_next.rx_hold = rx_ev.word;
      st_next.frame[ssc_pkg::FC_RX9] = rx_ev.word[8];
      st_next.idle_armed = 1'b1;
    end
    // Wake-up of muted receiver
    if (run && muted) begin
      if (st_reg.mode_live[0] && rx_ev.word_done && rx_ev.addr_mark) begin
        st_next.enable[ssc_pkg::EC_MUTE] = 1'b0;
        st_next.rx_hold = rx_ev.word;
        st_next.status[ssc_pkg::ST_RXR] = 1'b1;
      end else if (!st_reg.mode_live[0] && rx_ev.idle_line) begin
        st_next.enable[ssc_pkg::EC_MUTE] = 1'b0;
      end
    end
    // Register writes
    if (wr && paddr == ssc_pkg::OFS_FRAME) begin
      st_next.frame[6:0] = pwdata[6:0];
    end
    if (wr && paddr == ssc_pkg::OFS_ENABLE) begin
      st_next.enable = pwdata[7:0];
    end
    // Hardware sets win over clears
    st_next.status = st_next.status | flags_in;
    // Read data mux; captured in the setup cycle so it stands during the access
    st_next.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ssc_pkg::OFS_STATUS: st_next.prdata[7:0] = st_reg.status;
        ssc_pkg::OFS_FRAME: st_next.prdata[7:0] = st_reg.frame;
        ssc_pkg::OFS_ENABLE: st_next.prdata[7:0] = st_reg.enable;
        ssc_pkg::OFS_DATA: st_next.prdata[7:0] = st_reg.rx_hold[7:0];
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end
  end

  // Shared interrupt; halt blocks wake, wait does not
  always_comb begin
    wake_request = st_reg.enable[ssc_pkg::EC_TIE] && st_reg.status[ssc_pkg::ST_TXE]
      || st_reg.enable[ssc_pkg::EC_TRANSMIT_COMPLETE_IRQ_EN] && st_reg.status[ssc_pkg::ST_TXC]
      || st_reg.enable[ssc_pkg::EC_RIE] && !muted
         && (st_reg.status[ssc_pkg::ST_RXR] || st_reg.status[ssc_pkg::ST_OVR])
      || st_reg.enable[ssc_pkg::EC_IDLE_IRQ_EN] && !muted && st_reg.status[ssc_pkg::ST_IDLE]
      || st_reg.frame[ssc_pkg::FC_PIE] && !muted && st_reg.status[ssc_pkg::ST_PAR];
    wake_request = wake_request && !st_reg.halt_sync[1];
    irq = wake_request && !global_mask;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.status <= ssc_pkg::STATUS_RST;
      st_reg.frame <= ssc_pkg::FRAME_RST;
      st_reg.enable <= ssc_pkg::ENABLE_RST;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// *** ssc_core_properties.sv ***
// Port checker for the serial status/control core.
// Assumes binding onto ssc_core; a single pclk domain.
`timescale 1ns/1ps
`default_nettype none
module ssc_core_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus and processor state
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic global_mask,
  input wire logic halt_mode,
  // Engine side and interrupt
  input wire logic tx_load,
  input wire logic byte_boundary,
  input wire logic nine_bit,
  input wire logic parity_on,
  input wire logic parity_odd,
  input wire logic irq,
  input wire logic wake_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Halt held long enough to pass the synchroniser
  sequence s_halted;
    halt_mode [*3];
  endsequence
  property p_mask; global_mask |-> !irq; endproperty
  property p_wake; irq |-> wake_request; endproperty
  property p_halt_wake; s_halted |-> !wake_request; endproperty
  property p_halt_load; s_halted |-> !tx_load; endproperty
  property p_load_once; tx_load |=> !tx_load; endproperty
  property p_par_hold; !byte_boundary |=> $stable(parity_on); endproperty
  property p_odd_hold; !byte_boundary |=> $stable(parity_odd); endproperty
  property p_len_cause;
    $changed(nine_bit) |-> $past(psel && penable && pwrite && paddr == ssc_pkg::OFS_FRAME);
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  a_wake: assert property (p_wake) else $error("irq without wake");
  a_halt_wake: assert property (p_halt_wake) else $error("wake in halt");
  a_halt_load: assert property (p_halt_load) else $error("load in halt");
  a_load_once: assert property (p_load_once) else $error("double load");
  a_par_hold: assert property (p_par_hold) else $error("parity mid byte");
  a_odd_hold: assert property (p_odd_hold) else $error("sense mid byte");
  a_len_cause: assert property (p_len_cause) else $error("length moved");
endmodule
bind ssc_core ssc_core_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .global_mask(global_mask),
  .halt_mode(halt_mode), .tx_load(tx_load), .byte_boundary(byte_boundary),
  .nine_bit(nine_bit), .parity_on(parity_on), .parity_odd(parity_odd), .irq(irq),
  .wake_request(wake_request));
`default_nettype wire

// *** ssc_engine_model.sv ***
// Far-side engines: a transmit shifter and a bench-commanded receiver.
// Assumes the core's engine ports on the same pclk.
`timescale 1ns/1ps
`default_nettype none
module ssc_engine_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Transmit side
  input wire logic tx_load,
  output logic tx_shift_free,
  output logic tx_data_done,
  output logic byte_boundary,
  input wire logic tx_special,
  output logic tx_special_done,
  // Receive side
  input wire logic rx_go,
  input wire ssc_pkg::ssc_rx_ev_t rx_cmd,
  output ssc_pkg::ssc_rx_ev_t rx_ev
);
  logic [2:0] tx_cnt; // Cycles left in the frame
  assign tx_shift_free = (tx_cnt == 3'd0);
  assign byte_boundary = tx_data_done;
  // Preamble or break frames end with the special marker
  assign tx_special_done = tx_data_done && tx_special;
  // Frame timing and receive events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt <= 3'd0;
      tx_data_done <= 1'b0;
      rx_ev <= '0;
    end else begin
      tx_data_done <= (tx_cnt == 3'd1);
      if (tx_load) begin
        tx_cnt <= 3'd4;
      end else if (tx_cnt != 3'd0) begin
        tx_cnt <= tx_cnt - 3'd1;
      end
      rx_ev <= rx_go ? rx_cmd : '0;
      // Stale word lines keep toggling
      if (!rx_go) begin
        rx_ev.word <= ~rx_ev.word;
      end
    end
  end
endmodule
`default_nettype wire

// *** ssc_core_tb_top.sv ***
// Self-checking bench for the serial status/control core.
// Assumes ssc_core, its checker and the engine model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ssc_core_tb_top;
  logic pclk, presetn, psel, penable, pwrite, global_mask, halt_mode, rx_go;
  logic pready, pslverr, tx_load, tx_shift_free, tx_data_done, byte_boundary;
  logic tx_special, tx_special_done;
  logic engine_run, nine_bit, parity_on, parity_odd, wake_addr, irq, wake_request;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] tx_word, last_tx;
  ssc_pkg::ssc_rx_ev_t rx_ev, rx_cmd;
  int bad_count, samples_checked;
  ssc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_mask(global_mask), .halt_mode(halt_mode), .tx_load(tx_load),
    .tx_word(tx_word), .tx_shift_free(tx_shift_free), .tx_data_done(tx_data_done),
    .tx_special_done(tx_special_done), .byte_boundary(byte_boundary), .rx_ev(rx_ev),
    .engine_run(engine_run), .nine_bit(nine_bit), .parity_on(parity_on),
    .parity_odd(parity_odd), .wake_addr(wake_addr), .irq(irq), .wake_request(wake_request));
  ssc_engine_model u_far (.pclk(pclk), .presetn(presetn), .tx_load(tx_load),
    .tx_shift_free(tx_shift_free), .tx_data_done(tx_data_done),
    .byte_boundary(byte_boundary), .tx_special(tx_special),
    .tx_special_done(tx_special_done), .rx_go(rx_go), .rx_cmd(rx_cmd), .rx_ev(rx_ev));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Capture each word handed to the shifter
  always @(posedge pclk) if (tx_load === 1'b1) last_tx <= tx_word;
  // One APB transfer; read data lands in rd
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Status access, then a data write, then let the frame finish
  task automatic tx(input logic [7:0] d);
    apb(1'b0, ssc_pkg::OFS_STATUS, 0); apb(1'b1, ssc_pkg::OFS_DATA, {24'h0, d});
    repeat (8) @(posedge pclk);
  endtask
  task automatic rx_send(input logic [8:0] w, input logic n, input logic f);
    rx_cmd <= '{1'b1, w, n, f, 1'b0, 1'b0}; rx_go <= 1'b1;
    @(posedge pclk) rx_go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 0); chk({1'b0, rd[7:0]}, {1'b0, exp});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200us bad_count++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, global_mask, halt_mode, rx_go, tx_special} = '0;
    paddr = 8'h00; pwdata = 32'h0000_0000; rx_cmd = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(ssc_pkg::OFS_STATUS, 8'hC0);
    rd_chk(ssc_pkg::OFS_FRAME, 8'h00);
    rd_chk(8'h10, 8'h00);
    chk({7'h00, pready, pslverr}, 9'h002);
    $display("test reset done");
    apb(1'b1, ssc_pkg::OFS_ENABLE, 32'h0000_0080);
    chk({8'h00, irq}, 9'h001);
    global_mask <= 1'b1;
    @(posedge pclk);
    chk({8'h00, irq}, 9'h000);
    global_mask <= 1'b0;
    tx(8'h5A);
    chk(last_tx, 9'h05A);
    rd_chk(ssc_pkg::OFS_STATUS, 8'hC0);
    $display("test transmit done");
    apb(1'b1, ssc_pkg::OFS_ENABLE, 32'h0000_0020);
    rx_send(9'h033, 1'b0, 1'b0);
    rd_chk(ssc_pkg::OFS_STATUS, 8'hE0);
    chk({8'h00, irq}, 9'h001);
    rx_send(9'h044, 1'b0, 1'b0);
    rd_chk(ssc_pkg::OFS_STATUS, 8'hE8);
    rd_chk(ssc_pkg::OFS_DATA, 8'h33);
    rd_chk(ssc_pkg::OFS_STATUS, 8'hC0);
    rx_send(9'h055, 1'b1, 1'b1);
    rd_chk(ssc_pkg::OFS_STATUS, 8'hE6);
    apb(1'b0, ssc_pkg::OFS_DATA, 0);
    rd_chk(ssc_pkg::OFS_STATUS, 8'hC0);
    $display("test receive done");
    apb(1'b1, ssc_pkg::OFS_FRAME, 32'h0000_0050);
    chk({8'h00, nine_bit}, 9'h001);
    tx(8'h01);
    chk(last_tx, 9'h101);
    rx_send(9'h1AB, 1'b0, 1'b0);
    rd_chk(ssc_pkg::OFS_FRAME, 8'hD0);
    halt_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({7'h00, engine_run, wake_request}, 9'h000);
    halt_mode <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, ssc_pkg::OFS_FRAME, 32'h0000_0056);
    chk({8'h00, parity_on}, 9'h000);
    tx(8'h02);
    chk({7'h00, parity_on, parity_odd}, 9'h003);
    $display("test format done");
    rd_chk(ssc_pkg::OFS_STATUS, 8'hE0);
    apb(1'b0, ssc_pkg::OFS_DATA, 0);
    rx_send(9'h1AB, 1'b0, 1'b0);
    rd_chk(ssc_pkg::OFS_STATUS, 8'hE1);
    apb(1'b0, ssc_pkg::OFS_DATA, 0);
    rd_chk(ssc_pkg::OFS_STATUS, 8'hC0);
    tx_special <= 1'b1;
    tx(8'h03);
    chk(last_tx, 9'h103);
    rd_chk(ssc_pkg::OFS_STATUS, 8'h80);
    tx_special <= 1'b0;
    apb(1'b1, ssc_pkg::OFS_ENABLE, 32'h0000_0022);
    rx_send(9'h011, 1'b1, 1'b0);
    rd_chk(ssc_pkg::OFS_STATUS, 8'h80);
    chk({8'h00, wake_request}, 9'h000);
    $display("test parity and mute done");
    complete_run();
  end
endmodule
`default_nettype wire
